// [felu_defs.svh]
// Constants of the fault escalation and lockup unit.
`ifndef FELU_DEFS_SVH
`define FELU_DEFS_SVH

// Priority field width; a lower value is a higher priority.
`define FELU_PRI_W       3
`define FELU_ADDR_W      32
`define FELU_ADDR_RST    32'h0000_0000

// Hard fault cause bits.
`define FELU_HF_W        2
`define FELU_HF_TABLE_FETCH_BUS_ERROR_FLAG     0
`define FELU_HF_ESCALATION_FLAG   1
`define FELU_HF_RST      2'h0

// Memory management cause bits.
`define FELU_MM_W        4
`define FELU_MM_IACC     0
`define FELU_MM_DACC     1
`define FELU_MM_PUSH     2
`define FELU_MM_POP      3
`define FELU_MM_RST      4'h0

// Bus error cause bits.
`define FELU_BF_W        5
`define FELU_BF_PUSH     0
`define FELU_BF_POP      1
`define FELU_BF_PREF     2
`define FELU_BF_EXACT    3
`define FELU_BF_INEXACT  4
`define FELU_BF_RST      5'h00

// Usage cause bits.
`define FELU_UF_W        6
`define FELU_UF_CP       0
`define FELU_UF_UNKNOWN_OPCODE_FLAG    1
`define FELU_UF_STATE    2
`define FELU_UF_RET      3
`define FELU_UF_ALIGN    4
`define FELU_UF_ZERO_DIVISOR_FLAG     5
`define FELU_UF_RST      6'h00

`endif

// [felu_pkg.sv]
// Types shared by the fault escalation and lockup unit.
`include "felu_defs.svh"
`default_nettype none
package felu_pkg;

   // One-cycle fault events from pipeline, bus interface and MPU.
   typedef struct packed {
      logic table_fetch_bus_error_flag_bus_err;
      logic ifetch_mpu_viol;
      logic ifetch_never_execute;
      logic data_mpu_viol;
      logic push_mpu_viol;
      logic pop_mpu_viol;
      logic push_bus_err;
      logic pop_bus_err;
      logic prefetch_bus_err;
      logic data_bus_err;
      logic data_bus_exact;
      logic cp_access;
      logic unknown_op;
      logic leave_native_set;
      logic bad_multiple_continuation;
      logic bad_exception_return_code;
      logic misaligned;
      logic zero_divisor;
   } felu_ev_t;

   // Priority and handler enable settings, and the sleep select.
   typedef struct packed {
      logic [`FELU_PRI_W-1:0] pri_mem;
      logic [`FELU_PRI_W-1:0] pri_bus;
      logic [`FELU_PRI_W-1:0] pri_usage;
      logic                   en_mem;
      logic                   en_bus;
      logic                   en_usage;
      logic                   deep_sleep_select;
   } felu_cfg_t;

   // Software clear strobes, one per cause bit.
   typedef struct packed {
      logic [`FELU_HF_W-1:0] hard;
      logic [`FELU_MM_W-1:0] mem;
      logic [`FELU_BF_W-1:0] bus;
      logic [`FELU_UF_W-1:0] usage;
   } felu_clr_t;

   typedef enum logic [2:0] {
      FELU_CTX_THREAD = 3'h0,
      FELU_CTX_NMI    = 3'h1,
      FELU_CTX_HARD   = 3'h2,
      FELU_CTX_MEM    = 3'h3,
      FELU_CTX_BUS    = 3'h4,
      FELU_CTX_USAGE  = 3'h5,
      FELU_CTX_OTHER  = 3'h6
   } felu_ctx_t;

   typedef enum logic [2:0] {
      FELU_LK_RUN = 3'h1,
      FELU_LK_HF  = 3'h2,
      FELU_LK_NMI = 3'h4
   } felu_lock_t;

endpackage
`default_nettype wire

// [felu_escalate.sv]
// Decides which raised configurable faults must become hard faults.
`include "felu_defs.svh"
`default_nettype none
module felu_escalate (
   // Current execution context.
   input  wire felu_pkg::felu_ctx_t      ctx,
   input  wire logic [`FELU_PRI_W-1:0]   cur_pri,
   input  wire felu_pkg::felu_cfg_t      cfg,
   // Raised fault classes.
   input  wire logic                     raise_mem,
   input  wire logic                     raise_bus,
   input  wire logic                     raise_usage,
   input  wire logic                     bus_entry_push,
   // Escalation results.
   output logic                          esc_mem,
   output logic                          esc_bus,
   output logic                          esc_usage
);

   // Hard fault and NMI outrank every configurable priority.
   function automatic logic must_esc(
      input felu_pkg::felu_ctx_t    own,
      input logic [`FELU_PRI_W-1:0] pri,
      input logic                   en,
      input felu_pkg::felu_ctx_t    c,
      input logic [`FELU_PRI_W-1:0] cp
   );
      logic fixed_hi;
      logic in_hdl;
      fixed_hi = (c == felu_pkg::FELU_CTX_NMI) ||
                 (c == felu_pkg::FELU_CTX_HARD);
      in_hdl   = (c != felu_pkg::FELU_CTX_THREAD);
      must_esc = !en ||
                 (c == own) ||
                 fixed_hi ||
                 (in_hdl && pri >= cp);
   endfunction

   always_comb begin
      esc_mem   = raise_mem &&
                  must_esc(felu_pkg::FELU_CTX_MEM, cfg.pri_mem,
                           cfg.en_mem, ctx, cur_pri);
      // A push error while entering the bus handler stays a bus fault.
      esc_bus   = raise_bus && !bus_entry_push &&
                  must_esc(felu_pkg::FELU_CTX_BUS, cfg.pri_bus,
                           cfg.en_bus, ctx, cur_pri);
      esc_usage = raise_usage &&
                  must_esc(felu_pkg::FELU_CTX_USAGE, cfg.pri_usage,
                           cfg.en_usage, ctx, cur_pri);
   end

endmodule
`default_nettype wire

// [felu_sleep.sv]
// Light and deep sleep clock and power controls.
`default_nettype none
module felu_sleep (
   // Clock, reset and enable.
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // Sleep request and mode select.
   input  wire logic sleep_req,
   input  wire logic deep_sel,
   // Gating outputs.
   output logic      cpu_clk_stop,
   output logic      sys_clk_stop,
   output logic      pll_off,
   output logic      flash_off
);

   logic cpu_stop_r;
   logic deep_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_stop_r <= 1'b0;
         deep_r     <= 1'b0;
      end else if (ce) begin
         cpu_stop_r <= sleep_req;
         deep_r     <= sleep_req && deep_sel;
      end
   end

   assign cpu_clk_stop = cpu_stop_r;
   assign sys_clk_stop = deep_r;
   assign pll_off      = deep_r;
   assign flash_off    = deep_r;

   a_light_sleep_only:
   assert property (@(posedge clk) disable iff (!rst_n)
      ce && sleep_req && !deep_sel |=> cpu_clk_stop && !sys_clk_stop
                                        && !pll_off && !flash_off)
      else $error("light sleep stopped more than the core clock");

   a_deep_sleep_sel:
   assert property (@(posedge clk) disable iff (!rst_n)
      ce && sleep_req && deep_sel |=> cpu_clk_stop && sys_clk_stop
                                      && pll_off && flash_off)
      else $error("deep sleep select did not stop clocks and power");

endmodule
`default_nettype wire

// [felu_core.sv]
// Fault classification, escalation, address capture and lockup.
`include "felu_defs.svh"
`default_nettype none
module felu_core (
   // Clock, reset and enable.
   input  wire logic                     CORE_CLK,
   input  wire logic                     RST_N,
   input  wire logic                     CE,
   // Fault events and the faulting access address.
   input  wire felu_pkg::felu_ev_t       FAULT_EV,
   input  wire logic [`FELU_ADDR_W-1:0]  FAULT_ADDR,
   input  wire logic                     ENTERING_BUS_HANDLER,
   // Execution context.
   input  wire felu_pkg::felu_ctx_t      CUR_CTX,
   input  wire logic [`FELU_PRI_W-1:0]   CUR_PRI,
   input  wire logic                     NMI,
   input  wire logic                     DBG_HALT,
   // Software settings and clears.
   input  wire felu_pkg::felu_cfg_t      CFG,
   input  wire felu_pkg::felu_clr_t      CLR,
   input  wire logic                     SLEEP_REQ,
   // Cause flags and addresses.
   output logic [`FELU_HF_W-1:0]         HARD_CAUSE,
   output logic [`FELU_MM_W-1:0]         MEM_CAUSE,
   output logic [`FELU_BF_W-1:0]         BUS_CAUSE,
   output logic [`FELU_UF_W-1:0]         USAGE_CAUSE,
   output logic [`FELU_ADDR_W-1:0]       MM_ADDR,
   output logic [`FELU_ADDR_W-1:0]       BUS_ADDR,
   // Exception requests and lockup.
   output logic                          TAKE_HARD,
   output logic                          TAKE_MEM,
   output logic                          TAKE_BUS,
   output logic                          TAKE_USAGE,
   output logic                          LOCKUP,
   // Sleep controls.
   output logic                          CPU_CLK_STOP,
   output logic                          SYS_CLK_STOP,
   output logic                          PLL_OFF,
   output logic                          FLASH_OFF
);

   felu_pkg::felu_lock_t          lock_r;
   felu_pkg::felu_lock_t          lock_nxt;
   logic [`FELU_HF_W-1:0]         hard_cause_r;
   logic [`FELU_MM_W-1:0]         mem_cause_r;
   logic [`FELU_BF_W-1:0]         bus_cause_r;
   logic [`FELU_UF_W-1:0]         usage_cause_r;
   logic [`FELU_HF_W-1:0]         hf_set;
   logic [`FELU_MM_W-1:0]         mm_set;
   logic [`FELU_BF_W-1:0]         bf_set;
   logic [`FELU_UF_W-1:0]         uf_set;
   logic [`FELU_ADDR_W-1:0]       mm_addr_r;
   logic [`FELU_ADDR_W-1:0]       bus_addr_r;
   logic                          take_hard_r;
   logic                          take_mem_r;
   logic                          take_bus_r;
   logic                          take_usage_r;
   logic                          run;
   logic                          raise_mem;
   logic                          raise_bus;
   logic                          raise_usage;
   logic                          esc_mem;
   logic                          esc_bus;
   logic                          esc_usage;
   logic                          esc_any;
   logic                          hard_raise;
   logic                          in_top_handler;

   // No instruction executes in lockup, so no new fault can arise.
   assign run = (lock_r == felu_pkg::FELU_LK_RUN);

   always_comb begin
      mm_set = `FELU_MM_RST;
      mm_set[`FELU_MM_IACC] = run && (FAULT_EV.ifetch_mpu_viol ||
                              FAULT_EV.ifetch_never_execute);
      mm_set[`FELU_MM_DACC] = run && FAULT_EV.data_mpu_viol;
      mm_set[`FELU_MM_PUSH] = run && FAULT_EV.push_mpu_viol;
      mm_set[`FELU_MM_POP]  = run && FAULT_EV.pop_mpu_viol;
      bf_set = `FELU_BF_RST;
      bf_set[`FELU_BF_PUSH] = run && FAULT_EV.push_bus_err;
      bf_set[`FELU_BF_POP]  = run && FAULT_EV.pop_bus_err;
      bf_set[`FELU_BF_PREF] = run && FAULT_EV.prefetch_bus_err;
      bf_set[`FELU_BF_EXACT] = run && FAULT_EV.data_bus_err &&
                               FAULT_EV.data_bus_exact;
      bf_set[`FELU_BF_INEXACT] = run && FAULT_EV.data_bus_err &&
                                 !FAULT_EV.data_bus_exact;
      uf_set = `FELU_UF_RST;
      uf_set[`FELU_UF_CP]    = run && FAULT_EV.cp_access;
      uf_set[`FELU_UF_UNKNOWN_OPCODE_FLAG] = run && FAULT_EV.unknown_op;
      uf_set[`FELU_UF_STATE] = run &&
                               (FAULT_EV.leave_native_set ||
                                FAULT_EV.bad_multiple_continuation);
      uf_set[`FELU_UF_RET]   = run &&
                               FAULT_EV.bad_exception_return_code;
      uf_set[`FELU_UF_ALIGN] = run && FAULT_EV.misaligned;
      uf_set[`FELU_UF_ZERO_DIVISOR_FLAG]  = run && FAULT_EV.zero_divisor;
   end

   assign raise_mem   = |mm_set;
   assign raise_bus   = |bf_set;
   assign raise_usage = |uf_set;

   felu_escalate u_escalate (
      .ctx            (CUR_CTX),
      .cur_pri        (CUR_PRI),
      .cfg            (CFG),
      .raise_mem      (raise_mem),
      .raise_bus      (raise_bus),
      .raise_usage    (raise_usage),
      .bus_entry_push (FAULT_EV.push_bus_err && ENTERING_BUS_HANDLER),
      .esc_mem        (esc_mem),
      .esc_bus        (esc_bus),
      .esc_usage      (esc_usage)
   );

   assign esc_any        = esc_mem || esc_bus || esc_usage;
   assign hard_raise     = run && (FAULT_EV.table_fetch_bus_error_flag_bus_err || esc_any);
   assign in_top_handler = (CUR_CTX == felu_pkg::FELU_CTX_NMI) ||
                           (CUR_CTX == felu_pkg::FELU_CTX_HARD);

   always_comb begin
      hf_set = `FELU_HF_RST;
      hf_set[`FELU_HF_TABLE_FETCH_BUS_ERROR_FLAG]   = run && FAULT_EV.table_fetch_bus_error_flag_bus_err;
      hf_set[`FELU_HF_ESCALATION_FLAG] = run && esc_any;
   end

   // A new cause wins over a clear in the same cycle.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         hard_cause_r  <= `FELU_HF_RST;
         mem_cause_r   <= `FELU_MM_RST;
         bus_cause_r   <= `FELU_BF_RST;
         usage_cause_r <= `FELU_UF_RST;
      end else if (CE) begin
         hard_cause_r  <= (hard_cause_r & ~CLR.hard) | hf_set;
         mem_cause_r   <= (mem_cause_r & ~CLR.mem) | mm_set;
         bus_cause_r   <= (bus_cause_r & ~CLR.bus) | bf_set;
         usage_cause_r <= (usage_cause_r & ~CLR.usage) | uf_set;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mm_addr_r  <= `FELU_ADDR_RST;
         bus_addr_r <= `FELU_ADDR_RST;
      end else if (CE) begin
         if (raise_mem) begin
            mm_addr_r <= FAULT_ADDR;
         end
         if (raise_bus) begin
            bus_addr_r <= FAULT_ADDR;
         end
      end
   end

   // A hard fault masks the lower fault requests of the same cycle.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         take_hard_r  <= 1'b0;
         take_mem_r   <= 1'b0;
         take_bus_r   <= 1'b0;
         take_usage_r <= 1'b0;
      end else if (CE) begin
         take_hard_r  <= hard_raise && !in_top_handler;
         take_mem_r   <= raise_mem && !esc_mem && !hard_raise;
         take_bus_r   <= raise_bus && !esc_bus && !hard_raise;
         take_usage_r <= raise_usage && !esc_usage && !hard_raise;
      end
   end

   always_comb begin
      lock_nxt = lock_r;
      unique case (lock_r)
         felu_pkg::FELU_LK_RUN: begin
            if (hard_raise && in_top_handler) begin
               lock_nxt = (CUR_CTX == felu_pkg::FELU_CTX_NMI) ?
                          felu_pkg::FELU_LK_NMI : felu_pkg::FELU_LK_HF;
            end
         end
         felu_pkg::FELU_LK_HF: begin
            if (NMI || DBG_HALT) begin
               lock_nxt = felu_pkg::FELU_LK_RUN;
            end
         end
         felu_pkg::FELU_LK_NMI: begin
            if (DBG_HALT) begin
               lock_nxt = felu_pkg::FELU_LK_RUN;
            end
         end
         default: lock_nxt = felu_pkg::FELU_LK_RUN;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         lock_r <= felu_pkg::FELU_LK_RUN;
      end else if (CE) begin
         lock_r <= lock_nxt;
      end
   end

   felu_sleep u_sleep (
      .clk          (CORE_CLK),
      .rst_n        (RST_N),
      .ce           (CE),
      .sleep_req    (SLEEP_REQ),
      .deep_sel     (CFG.deep_sleep_select),
      .cpu_clk_stop (CPU_CLK_STOP),
      .sys_clk_stop (SYS_CLK_STOP),
      .pll_off      (PLL_OFF),
      .flash_off    (FLASH_OFF)
   );

   assign HARD_CAUSE  = hard_cause_r;
   assign MEM_CAUSE   = mem_cause_r;
   assign BUS_CAUSE   = bus_cause_r;
   assign USAGE_CAUSE = usage_cause_r;
   assign MM_ADDR     = mm_addr_r;
   assign BUS_ADDR    = bus_addr_r;
   assign TAKE_HARD   = take_hard_r;
   assign TAKE_MEM    = take_mem_r;
   assign TAKE_BUS    = take_bus_r;
   assign TAKE_USAGE  = take_usage_r;
   assign LOCKUP      = !run;

   a_table_fetch_bus_error_flag_hard_flag:
   assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && run && FAULT_EV.table_fetch_bus_error_flag_bus_err
      |=> HARD_CAUSE[`FELU_HF_TABLE_FETCH_BUS_ERROR_FLAG] && (TAKE_HARD || LOCKUP))
      else $error("vector read error not raised as hard fault");

   a_escalate_flag:
   assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && run && esc_any |=> HARD_CAUSE[`FELU_HF_ESCALATION_FLAG])
      else $error("escalation did not set its flag");

   a_never_exec_fetch:
   assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && run && FAULT_EV.ifetch_never_execute
      |=> MEM_CAUSE[`FELU_MM_IACC])
      else $error("never-execute fetch did not fault");

   a_stack_flags:
   assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && run && FAULT_EV.pop_mpu_viol && !FAULT_EV.push_mpu_viol
      && !mem_cause_r[`FELU_MM_PUSH] && !CLR.mem[`FELU_MM_POP]
      |=> MEM_CAUSE[`FELU_MM_POP] && !MEM_CAUSE[`FELU_MM_PUSH])
      else $error("unstacking violation set the wrong flag");

   a_exact_or_not:
   assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && run && FAULT_EV.data_bus_err && FAULT_EV.data_bus_exact
      && !bus_cause_r[`FELU_BF_INEXACT]
      |=> BUS_CAUSE[`FELU_BF_EXACT] && !BUS_CAUSE[`FELU_BF_INEXACT])
      else $error("exact data bus error flagged wrongly");

   a_bad_state_flag:
   assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && run && FAULT_EV.bad_multiple_continuation
      |=> USAGE_CAUSE[`FELU_UF_STATE])
      else $error("continuation return did not flag bad state");

   a_disabled_handler:
   assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && run && raise_usage && !CFG.en_usage
      |=> !TAKE_USAGE && (TAKE_HARD || LOCKUP))
      else $error("fault with disabled handler not escalated");

   a_bus_entry_push:
   assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && run && FAULT_EV.push_bus_err && ENTERING_BUS_HANDLER
      && CFG.en_bus && CUR_CTX == felu_pkg::FELU_CTX_THREAD
      && !FAULT_EV.table_fetch_bus_error_flag_bus_err && !raise_mem && !raise_usage
      |=> TAKE_BUS && !TAKE_HARD)
      else $error("bus handler entry push error escalated");

   a_mm_address:
   assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && raise_mem |=> MM_ADDR == $past(FAULT_ADDR))
      else $error("memory fault address not captured");

   a_lockup_entry:
   assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && hard_raise && CUR_CTX == felu_pkg::FELU_CTX_HARD
      |=> LOCKUP && !TAKE_HARD)
      else $error("hard fault in hard handler did not lock up");

   a_nmi_lock_holds:
   assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      lock_r == felu_pkg::FELU_LK_NMI && !DBG_HALT |=> LOCKUP)
      else $error("nmi released lockup entered from nmi handler");

   a_flag_sticky:
   assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      USAGE_CAUSE[`FELU_UF_ZERO_DIVISOR_FLAG] && !(CE && CLR.usage[`FELU_UF_ZERO_DIVISOR_FLAG])
      |=> USAGE_CAUSE[`FELU_UF_ZERO_DIVISOR_FLAG])
      else $error("cause flag dropped without a clear");

endmodule
`default_nettype wire

// [felu_far_model.sv]
// Far side model: pipeline, bus interface and MPU fault event source.
`default_nettype none
module felu_far_model (
   // Clock.
   input  wire logic          clk,
   // Fault event and faulting address toward the core.
   output var felu_pkg::felu_ev_t ev,
   output var logic [31:0]    addr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ev = '0;
      addr = 32'h0000_0000;
   end
   // An event stands one cycle; the released address shows its inverse.
   task automatic fire(input logic [17:0] m, input logic [31:0] a);
      @(negedge clk);
      ev = m;
      addr = a;
      @(negedge clk);
      ev = '0;
      addr = ~a;
   endtask
endmodule
`default_nettype wire

// [tb_felu_core.sv]
// Self-checking bench for the fault escalation and lockup unit.
`include "felu_defs.svh"
`default_nettype none
module tb_felu_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic                core_clk = 1'b0;
   logic                rst_n = 1'b0;
   logic                entering = 1'b0;
   logic                nmi = 1'b0;
   logic                dbg_halt = 1'b0;
   logic                ce = 1'b1;
   logic                sleep_req = 1'b0;
   logic [2:0]          cur_pri = 3'h0;
   felu_pkg::felu_ctx_t cur_ctx = felu_pkg::FELU_CTX_THREAD;
   felu_pkg::felu_cfg_t cfg = '{3'h2, 3'h3, 3'h4, 1'b1, 1'b1, 1'b1, 1'b0};
   felu_pkg::felu_clr_t clr = '0;
   felu_pkg::felu_ev_t  ev;
   logic [31:0]         fa, mm_a, bus_a;
   logic [1:0]          hard_c;
   logic [3:0]          mem_c, take, slp;
   logic [4:0]          bus_c;
   logic [5:0]          use_c;
   logic                lockup;
   logic [16:0]         causes;
   int                  miscompares = 0;
   int                  samples_checked = 0;
   logic [17:0] m_tab [18] = '{18'h20000, 18'h10000, 18'h08000, 18'h04000,
      18'h02000, 18'h01000, 18'h00800, 18'h00400, 18'h00200, 18'h00180,
      18'h00100, 18'h00040, 18'h00020, 18'h00010, 18'h00008, 18'h00004,
      18'h00002, 18'h00001};
   int k_tab [18] = '{0, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3};
   int b_tab [18] = '{15 + `FELU_HF_TABLE_FETCH_BUS_ERROR_FLAG, 11 + `FELU_MM_IACC,
      11 + `FELU_MM_IACC, 11 + `FELU_MM_DACC, 11 + `FELU_MM_PUSH,
      11 + `FELU_MM_POP, 6 + `FELU_BF_PUSH, 6 + `FELU_BF_POP,
      6 + `FELU_BF_PREF, 6 + `FELU_BF_EXACT, 6 + `FELU_BF_INEXACT,
      `FELU_UF_CP, `FELU_UF_UNKNOWN_OPCODE_FLAG, `FELU_UF_STATE, `FELU_UF_STATE,
      `FELU_UF_RET, `FELU_UF_ALIGN, `FELU_UF_ZERO_DIVISOR_FLAG};
   assign causes = {hard_c, mem_c, bus_c, use_c};
   always #2 core_clk = ~core_clk;
   felu_far_model u_far (.clk(core_clk), .ev(ev), .addr(fa));
   felu_core u_dut (
      .CORE_CLK(core_clk), .RST_N(rst_n), .CE(ce), .FAULT_EV(ev),
      .FAULT_ADDR(fa), .ENTERING_BUS_HANDLER(entering), .CUR_CTX(cur_ctx),
      .CUR_PRI(cur_pri), .NMI(nmi), .DBG_HALT(dbg_halt), .CFG(cfg),
      .CLR(clr), .SLEEP_REQ(sleep_req), .HARD_CAUSE(hard_c),
      .MEM_CAUSE(mem_c), .BUS_CAUSE(bus_c), .USAGE_CAUSE(use_c),
      .MM_ADDR(mm_a), .BUS_ADDR(bus_a), .TAKE_HARD(take[3]),
      .TAKE_MEM(take[2]), .TAKE_BUS(take[1]), .TAKE_USAGE(take[0]),
      .LOCKUP(lockup), .CPU_CLK_STOP(slp[3]), .SYS_CLK_STOP(slp[2]),
      .PLL_OFF(slp[1]), .FLASH_OFF(slp[0]));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // One cycle of the debugger halt when dbg is set, of NMI otherwise.
   task automatic pulse(input logic dbg);
      @(negedge core_clk);
      nmi = !dbg;
      dbg_halt = dbg;
      @(negedge core_clk);
      nmi = 1'b0;
      dbg_halt = 1'b0;
   endtask
   task automatic clr_all;
      @(negedge core_clk);
      clr = '1;
      @(negedge core_clk);
      clr = '0;
      chk(causes, 32'h0);
   endtask
   task automatic run(input felu_pkg::felu_ctx_t c, input logic [2:0] p,
         input logic [17:0] m, input logic [3:0] tk, input logic [1:0] h);
      clr_all();
      cur_ctx = c;
      cur_pri = p;
      u_far.fire(m, 32'h0000_1000);
      chk(take, tk);
      chk(hard_c, h);
   endtask
   // Lockup may follow the hard fault answer by one cycle.
   task automatic lock(input logic [17:0] m);
      u_far.fire(m, 32'h0000_0040);
      if (lockup !== 1'b1)
         @(negedge core_clk);
      chk(lockup, 1'b1);
   endtask
   initial begin
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      chk({causes, take, lockup, slp}, 32'h0);
      for (int i = 0; i < 18; i++) begin
         clr_all();
         u_far.fire(m_tab[i], 32'h2000_0000 + i);
         chk(causes, 32'h1 << b_tab[i]);
         chk(take, 4'h8 >> k_tab[i]);
         if (k_tab[i] == 1)
            chk(mm_a, 32'h2000_0000 + i);
         if (k_tab[i] == 2)
            chk(bus_a, 32'h2000_0000 + i);
      end
      u_far.fire(18'h00002, 32'h0);
      chk(use_c, 6'h1 << `FELU_UF_ZERO_DIVISOR_FLAG | 6'h1 << `FELU_UF_ALIGN);
      cfg.en_usage = 1'b0;
      run(felu_pkg::FELU_CTX_THREAD, 3'h0, 18'h1, 4'h8, 2'h2);
      cfg.en_usage = 1'b1;
      run(felu_pkg::FELU_CTX_MEM, 3'h2, 18'h10000, 4'h8, 2'h2);
      run(felu_pkg::FELU_CTX_USAGE, 3'h4, 18'h10000, 4'h4, 2'h0);
      run(felu_pkg::FELU_CTX_BUS, 3'h3, 18'h00001, 4'h8, 2'h2);
      run(felu_pkg::FELU_CTX_OTHER, 3'h3, 18'h00200, 4'h8, 2'h2);
      run(felu_pkg::FELU_CTX_OTHER, 3'h4, 18'h00200, 4'h2, 2'h0);
      run(felu_pkg::FELU_CTX_OTHER, 3'h0, 18'h04000, 4'h8, 2'h2);
      entering = 1'b1;
      run(felu_pkg::FELU_CTX_BUS, 3'h3, 18'h00800, 4'h2, 2'h0);
      entering = 1'b0;
      clr_all();
      cur_ctx = felu_pkg::FELU_CTX_HARD;
      lock(18'h20000);
      u_far.fire(18'h00001, 32'h0);
      chk(use_c, 32'h0);
      pulse(1'b0);
      chk(lockup, 1'b0);
      cur_ctx = felu_pkg::FELU_CTX_NMI;
      lock(18'h00002);
      pulse(1'b0);
      chk(lockup, 1'b1);
      pulse(1'b1);
      chk(lockup, 1'b0);
      cur_ctx = felu_pkg::FELU_CTX_THREAD;
      sleep_req = 1'b1;
      @(negedge core_clk);
      chk(slp, 4'h8);
      cfg.deep_sleep_select = 1'b1;
      @(negedge core_clk);
      chk(slp, 4'hf);
      // With the enable low, neither events nor sleep changes land.
      ce = 1'b0;
      sleep_req = 1'b0;
      u_far.fire(18'h00001, 32'h0);
      chk({use_c, slp}, {6'h10, 4'hf});
      ce = 1'b1;
      test_done();
   end
   initial begin
      repeat (2000) @(posedge core_clk);
      miscompares++;
      test_done();
   end
endmodule
`default_nettype wire
